// file: core/dchr_pkg.sv
/*
  Constants and types of the D-channel HDLC receive path.
  Assumes a deframer on aclk upstream.
*/
package dchr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_TEI = 8'h04;
  localparam logic [7:0] OFS_SAPI = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_SAPI_CAPTURE_REG = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_CNT = 8'h1C;
  localparam logic [7:0] OFS_DATA = 8'h20;
  // Reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [15:0] CMP_RST = 16'h0000;
  // Message mode select codes
  localparam logic [2:0] MODE_TM1 = 3'h5;
  localparam logic [2:0] MODE_TM2 = 3'h6;
  localparam logic [2:0] MODE_TM3 = 3'h7;
  localparam logic [2:0] MODE_RSVD = 3'h4;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  // Fixed group addresses
  localparam logic [7:0] GRP_TEI = 8'hFF;
  localparam logic [7:0] GRP_SAPI_A = 8'hFE;
  localparam logic [7:0] GRP_SAPI_B = 8'hFC;
  // Pool geometry
  localparam int POOL_BYTES = 32;
  localparam int POOLS = 2;
  // Frame status field positions
  localparam int ST_CRC = 0;
  localparam int ST_RAB = 1;
  localparam int ST_RDA = 2;
  localparam int ST_RDO = 3;
  localparam int ST_TA = 4;
  localparam int ST_SA = 5;
  localparam int ST_CR = 7;
  // Byte roles within the header
  localparam logic [2:0] ROLE_FIFO = 3'h0;
  localparam logic [2:0] ROLE_SAPI = 3'h1;
  localparam logic [2:0] ROLE_TEI = 3'h2;
  localparam logic [2:0] ROLE_SAPI_CAPTURE_REG = 3'h3;
  localparam logic [2:0] ROLE_CTRL1 = 3'h4;
  localparam logic [2:0] ROLE_CTRL2 = 3'h5;
  localparam logic [2:0] ROLE_DROP = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic sof;
    logic valid;
    logic [7:0] data;
    logic is_crc;
    logic eof;
    logic crc_ok;
    logic abort;
  } dchr_rx_t;

  typedef struct packed {
    logic is_end;
    logic [7:0] status;
    logic [5:0] base;
    logic [5:0] cnt;
    logic [11:0] len;
  } dchr_evt_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_BODY = 4'h2,
    RX_DROP = 4'h4,
    RX_ENDW = 4'h8
  } dchr_state_t;
endpackage

// file: core/dchr_rx_core.sv
/*
  D-channel HDLC receive path: address match, header capture, two pools,
  event queue with frame status, AXI4-Lite slave.
  Assumes rx_in from a deframer on aclk; sof and eof come on byteless cycles.
*/
// Notes on behaviour
// (RULE_01) Mode 101 checks second byte against TEIs
// (RULE_02) Mode 101 routes SAPI, control to registers, rest to FIFO
// (RULE_03) Mode 110 stores whole frame including CRC
// (RULE_04) Mode 111 checks first byte against SAPIs
// (RULE_05) Receive buffer is two 32-byte pools
// (RULE_06) Pool-full event per stored 32-byte block
// (RULE_07) Message-end event when frame completes
// (RULE_08) Up to two short messages held
// (RULE_09) Group TEI only with two-byte address
// (RULE_10) Auto modulo-128 I frame control compressed
// (RULE_11) Extended control: second byte into FIFO
// (RULE_12) Host serves pool-full within 32 bytes
// (RULE_13) Next message may use leftover pool space
// (RULE_14) Full memory: data and frame overflow
// (RULE_15) Events queued with status, shown singly
// (RULE_16) Host acknowledges with message-complete command
// (RULE_17) Acknowledge frees pool, shows next event
// (RULE_18) TEI match reported except modes 110/111
// (RULE_19) Status: CRC, data, abort, overflow
// (RULE_20) Five-bit FIFO count, twelve-bit length
// (RULE_21) Non-auto control capture after address bytes
// (RULE_22) Auto mode keeps plain modulo-8 control
// (RULE_23) Non-auto accepts all valid addresses
// (RULE_24) Occupied pools discard bytes, flag overflow
`timescale 1ns/1ps
module dchr_rx_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Deframed receive stream
  input wire dchr_pkg::dchr_rx_t rx_in,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int DEPTH = dchr_pkg::POOLS * dchr_pkg::POOL_BYTES;
  localparam logic [6:0] DEPTH7 = 7'(DEPTH);
  localparam logic [5:0] LAST_IN_BLK = 6'(dchr_pkg::POOL_BYTES - 1);
  localparam logic [5:0] BLK_CNT = 6'(dchr_pkg::POOL_BYTES);
  localparam logic [1:0] QMAX = 2'(dchr_pkg::POOLS);

  function automatic logic [2:0] byte_role(input logic [2:0] m, input logic ext, input logic [2:0] idx);
    logic [2:0] r;
    r = dchr_pkg::ROLE_FIFO;
    if (!m[2])
    begin
      if (m[0])
      begin
        if (idx == 3'h0) r = dchr_pkg::ROLE_SAPI;
        else if (idx == 3'h1) r = dchr_pkg::ROLE_TEI;
        else if (idx == 3'h2) r = dchr_pkg::ROLE_CTRL1; // RULE_21
        else if (idx == 3'h3 && ext) r = dchr_pkg::ROLE_CTRL2; // RULE_11
      end
      else
      begin
        if (idx == 3'h0) r = dchr_pkg::ROLE_TEI;
        else if (idx == 3'h1) r = dchr_pkg::ROLE_CTRL1; // RULE_21
        else if (idx == 3'h2 && ext) r = dchr_pkg::ROLE_CTRL2; // RULE_11
      end
    end
    else if (m == dchr_pkg::MODE_TM1)
    begin
      if (idx == 3'h0) r = dchr_pkg::ROLE_SAPI_CAPTURE_REG; // RULE_02
      else if (idx == 3'h1) r = dchr_pkg::ROLE_TEI; // RULE_01
      else if (idx == 3'h2) r = dchr_pkg::ROLE_CTRL1; // RULE_02
    end
    else if (m == dchr_pkg::MODE_TM3)
    begin
      if (idx == 3'h0) r = dchr_pkg::ROLE_SAPI; // RULE_04
    end
    else if (m == dchr_pkg::MODE_RSVD)
    begin
      r = dchr_pkg::ROLE_DROP;
    end
    return r;
  endfunction

  function automatic logic [7:0] mk_status(input logic crc, input logic ab, input logic rx_data_available, input logic rx_data_overflow,
                                           input logic ta, input logic [1:0] sa, input logic cr);
    logic [7:0] s;
    s = 8'h00;
    s[dchr_pkg::ST_CRC] = crc;
    s[dchr_pkg::ST_RAB] = ab;
    s[dchr_pkg::ST_RDA] = rx_data_available;
    s[dchr_pkg::ST_RDO] = rx_data_overflow;
    s[dchr_pkg::ST_TA] = ta;
    s[dchr_pkg::ST_SA +: 2] = sa;
    s[dchr_pkg::ST_CR] = cr;
    return s;
  endfunction

  function automatic logic [15:0] wm16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Configuration
  logic [3:0] mode_q;
  logic [15:0] tei_q;
  logic [15:0] sapi_q;
  logic fovf_q;
  // Capture registers
  logic [7:0] sapi_capture_reg_q;
  logic [7:0] sapi_capture_reg_pend_q;
  logic [7:0] ctrl_q;
  // Frame state
  dchr_pkg::dchr_state_t st_q;
  dchr_pkg::dchr_state_t st_d;
  logic [2:0] idx_q;
  logic [5:0] cur_cnt_q;
  logic [11:0] len_q;
  logic [5:0] blk_base_q;
  logic rdo_q;
  logic ta_q;
  logic [1:0] sa_q;
  logic cr_q;
  logic end_crc_q;
  logic end_ab_q;
  // Pool memory and event queue
  logic [7:0] mem_q [DEPTH];
  logic [5:0] wp_q;
  logic [5:0] rp_q;
  logic [6:0] fill_q;
  dchr_pkg::dchr_evt_t q_q [dchr_pkg::POOLS];
  logic [1:0] q_cnt_q;
  // Bus state
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Bus decode
  wire do_wr = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire wr_mode = do_wr & (wa == dchr_pkg::OFS_MODE);
  wire wr_tei = do_wr & (wa == dchr_pkg::OFS_TEI);
  wire wr_sapi = do_wr & (wa == dchr_pkg::OFS_SAPI);
  wire wr_cmd = do_wr & (wa == dchr_pkg::OFS_CMD) & w_strb_q[0];
  wire wr_hit = (wa == dchr_pkg::OFS_MODE) | (wa == dchr_pkg::OFS_TEI) | (wa == dchr_pkg::OFS_SAPI) |
                (wa == dchr_pkg::OFS_CMD);
  wire rd_data = ar_take & (ra == dchr_pkg::OFS_DATA);

  // Mode decode
  wire [2:0] msel = mode_q[2:0];
  wire ext_ctl = mode_q[3];
  wire auto_md = (msel[2:1] == dchr_pkg::MODE_AUTO);
  wire tm2 = (msel == dchr_pkg::MODE_TM2);
  wire tm1 = (msel == dchr_pkg::MODE_TM1);

  // Byte classification
  wire [7:0] b = rx_in.data;
  wire byte_v = rx_in.valid & (st_q == dchr_pkg::RX_BODY);
  wire [2:0] role = byte_role(msel, ext_ctl, idx_q);
  wire compress = auto_md & (ctrl_q[0] == 1'b0); // RULE_10 RULE_22
  wire to_fifo = (role == dchr_pkg::ROLE_FIFO) | ((role == dchr_pkg::ROLE_CTRL2) & ~compress); // RULE_11
  wire crc_skip = rx_in.is_crc & ~tm2; // RULE_03
  wire want = byte_v & to_fifo & ~crc_skip;
  wire room = (fill_q < DEPTH7) & ((cur_cnt_q < LAST_IN_BLK) | (q_cnt_q < QMAX)); // RULE_13
  wire store = want & room;
  wire ovf = want & ~room; // RULE_24
  wire sa_a = (b[7:2] == sapi_q[7:2]);
  wire sa_b = (b[7:2] == sapi_q[15:10]);
  wire sa_g = (b[7:2] == dchr_pkg::GRP_SAPI_A[7:2]) | (b[7:2] == dchr_pkg::GRP_SAPI_B[7:2]); // RULE_04
  wire [1:0] sa_code = sa_a ? 2'h1 : (sa_b ? 2'h2 : (sa_g ? 2'h3 : 2'h0));
  wire tei_hit = (b == tei_q[7:0]) | (b == tei_q[15:8]) | (msel[0] & (b == dchr_pkg::GRP_TEI)); // RULE_01 RULE_09
  wire is_sapi = byte_v & (role == dchr_pkg::ROLE_SAPI);
  wire is_tei = byte_v & (role == dchr_pkg::ROLE_TEI);
  wire miss = (is_sapi & (sa_code == 2'h0)) | (is_tei & ~tei_hit) |
              (byte_v & (role == dchr_pkg::ROLE_DROP)); // RULE_23

  // Frame start and end
  wire refuse = (fill_q == DEPTH7) | (q_cnt_q == QMAX); // RULE_14
  wire sof_idle = rx_in.sof & (st_q == dchr_pkg::RX_IDLE);
  wire accept = sof_idle & ~refuse;
  wire fovf_set = (sof_idle & refuse) | (rx_in.sof & (st_q == dchr_pkg::RX_ENDW)); // RULE_14
  wire end_ev = rx_in.eof & (st_q == dchr_pkg::RX_BODY);
  wire end_now = end_ev | (st_q == dchr_pkg::RX_ENDW);
  wire pop = wr_cmd & w_data_q[0] & (q_cnt_q != 2'h0); // RULE_17
  wire q_free = (q_cnt_q != QMAX) | pop;
  wire push_rme = end_now & q_free; // RULE_07
  wire push_rpf = store & (cur_cnt_q == LAST_IN_BLK); // RULE_06
  wire push = push_rme | push_rpf;
  wire fin_crc = end_ev ? rx_in.crc_ok : end_crc_q;
  wire fin_ab = end_ev ? rx_in.abort : end_ab_q;
  wire [5:0] fin_cnt = push_rpf ? BLK_CNT : cur_cnt_q;
  wire [7:0] fin_st = mk_status(fin_crc, fin_ab, cur_cnt_q != 6'h00, rdo_q | ovf, ta_q, sa_q, cr_q); // RULE_19
  wire [11:0] len_n = len_q + {11'h000, store};
  wire dchr_pkg::dchr_evt_t push_e = '{is_end: push_rme, status: fin_st, base: blk_base_q,
                                      cnt: fin_cnt, len: len_n}; // RULE_15
  wire [1:0] wslot = q_cnt_q - {1'b0, pop};
  wire dchr_pkg::dchr_evt_t head = q_q[0];
  wire [6:0] fill_d = fill_q + {6'h00, store} - (pop ? {1'b0, head.cnt} : 7'h00); // RULE_17

  // Register read selection
  wire hd_v = (q_cnt_q != 2'h0);
  wire [31:0] stat_w = {14'h0000, q_cnt_q, (hd_v ? head.status : 8'h00), 5'h00, fovf_q,
                        hd_v & head.is_end, hd_v & ~head.is_end}; // RULE_15
  wire [31:0] cnt_w = hd_v ? {4'h0, head.len, 11'h000, head.cnt[4:0]} : 32'h0000_0000; // RULE_20
  wire rd_hit = (ra == dchr_pkg::OFS_MODE) | (ra == dchr_pkg::OFS_TEI) | (ra == dchr_pkg::OFS_SAPI) |
                (ra == dchr_pkg::OFS_CMD) | (ra == dchr_pkg::OFS_STAT) | (ra == dchr_pkg::OFS_SAPI_CAPTURE_REG) |
                (ra == dchr_pkg::OFS_CTRL) | (ra == dchr_pkg::OFS_CNT) | rd_data;
  wire [31:0] rd_word =
    (ra == dchr_pkg::OFS_MODE) ? {28'h0000000, mode_q} :
    (ra == dchr_pkg::OFS_TEI) ? {16'h0000, tei_q} :
    (ra == dchr_pkg::OFS_SAPI) ? {16'h0000, sapi_q} :
    (ra == dchr_pkg::OFS_STAT) ? stat_w :
    (ra == dchr_pkg::OFS_SAPI_CAPTURE_REG) ? {24'h000000, sapi_capture_reg_q} :
    (ra == dchr_pkg::OFS_CTRL) ? {24'h000000, ctrl_q} :
    (ra == dchr_pkg::OFS_CNT) ? cnt_w :
    rd_data ? {24'h000000, mem_q[rp_q]} : 32'h0000_0000;

  // Next state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      dchr_pkg::RX_IDLE:
      begin
        if (sof_idle) st_d = refuse ? dchr_pkg::RX_DROP : dchr_pkg::RX_BODY;
      end
      dchr_pkg::RX_BODY:
      begin
        if (miss) st_d = dchr_pkg::RX_DROP;
        else if (end_ev) st_d = push_rme ? dchr_pkg::RX_IDLE : dchr_pkg::RX_ENDW;
      end
      dchr_pkg::RX_DROP:
      begin
        if (rx_in.eof) st_d = dchr_pkg::RX_IDLE;
      end
      dchr_pkg::RX_ENDW:
      begin
        if (push_rme) st_d = dchr_pkg::RX_IDLE;
      end
      default: st_d = dchr_pkg::RX_IDLE;
    endcase
  end

  // Software configuration; a frame overflow that coincides with its clear stays set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= dchr_pkg::MODE_RST;
      tei_q <= dchr_pkg::CMP_RST;
      sapi_q <= dchr_pkg::CMP_RST;
      fovf_q <= 1'b0;
    end
    else
    begin
      if (wr_mode && w_strb_q[0]) mode_q <= w_data_q[3:0];
      if (wr_tei) tei_q <= wm16(tei_q, w_data_q, w_strb_q);
      if (wr_sapi) sapi_q <= wm16(sapi_q, w_data_q, w_strb_q);
      fovf_q <= fovf_set | (fovf_q & ~(wr_cmd & w_data_q[1])); // RULE_14
    end
  end

  // Per-frame header tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= dchr_pkg::RX_IDLE;
      idx_q <= 3'h0;
      ta_q <= 1'b0;
      sa_q <= 2'h0;
      cr_q <= 1'b0;
      end_crc_q <= 1'b0;
      end_ab_q <= 1'b0;
      sapi_capture_reg_q <= 8'h00;
      sapi_capture_reg_pend_q <= 8'h00;
      ctrl_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      if (accept)
      begin
        idx_q <= 3'h0;
        ta_q <= 1'b0;
        sa_q <= 2'h0;
        cr_q <= 1'b0;
      end
      else if (byte_v && idx_q != 3'h4)
      begin
        idx_q <= idx_q + 3'h1;
      end
      if (end_ev)
      begin
        end_crc_q <= rx_in.crc_ok;
        end_ab_q <= rx_in.abort;
      end
      if (is_sapi)
      begin
        sa_q <= sa_code; // RULE_04
        cr_q <= b[1];
      end
      if (is_tei && tei_hit)
      begin
        ta_q <= 1'b1; // RULE_18
        if (tm1) sapi_capture_reg_q <= sapi_capture_reg_pend_q; // RULE_02
      end
      if (byte_v && role == dchr_pkg::ROLE_SAPI_CAPTURE_REG) sapi_capture_reg_pend_q <= b;
      if (byte_v && role == dchr_pkg::ROLE_CTRL1) ctrl_q <= b; // RULE_02 RULE_21 RULE_22
      else if (byte_v && role == dchr_pkg::ROLE_CTRL2 && compress) ctrl_q <= {b[3:0], ctrl_q[3:1], 1'b0}; // RULE_10
    end
  end

  // Pool storage and block accounting
  always_ff @(posedge aclk)
  begin
    if (store) mem_q[wp_q] <= b; // RULE_05
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_q <= 6'h00;
      rp_q <= 6'h00;
      fill_q <= 7'h00;
      cur_cnt_q <= 6'h00;
      len_q <= 12'h000;
      blk_base_q <= 6'h00;
      rdo_q <= 1'b0;
    end
    else
    begin
      fill_q <= fill_d; // RULE_08 RULE_13
      if (store) wp_q <= wp_q + 6'h01;
      if (pop) rp_q <= head.base + head.cnt; // RULE_17
      else if (rd_data) rp_q <= rp_q + 6'h01;
      if (accept)
      begin
        cur_cnt_q <= 6'h00;
        len_q <= 12'h000;
        blk_base_q <= wp_q;
        rdo_q <= 1'b0;
      end
      else
      begin
        if (store) len_q <= len_n; // RULE_20
        if (push_rpf)
        begin
          cur_cnt_q <= 6'h00;
          blk_base_q <= wp_q + 6'h01;
        end
        else if (store)
        begin
          cur_cnt_q <= cur_cnt_q + 6'h01;
        end
        if (ovf) rdo_q <= 1'b1; // RULE_24
      end
    end
  end

  // Event queue, head is presented to software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_cnt_q <= 2'h0;
      for (int i = 0; i < dchr_pkg::POOLS; i++) q_q[i] <= '0;
    end
    else
    begin
      q_cnt_q <= q_cnt_q + {1'b0, push} - {1'b0, pop};
      if (pop) q_q[0] <= q_q[1]; // RULE_17
      if (push) q_q[wslot[0]] <= push_e; // RULE_15
    end
  end

  // AXI4-Lite slave; address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dchr_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dchr_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take) aw_addr_q <= s_axi_awaddr[7:0];
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_held_q <= (aw_held_q | aw_take) & ~do_wr;
      w_held_q <= (w_held_q | w_take) & ~do_wr;
      s_axi_awready <= ~((aw_held_q | aw_take) & ~do_wr);
      s_axi_wready <= ~((w_held_q | w_take) & ~do_wr);
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? dchr_pkg::RESP_OKAY : dchr_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? dchr_pkg::RESP_OKAY : dchr_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
    end
  end
endmodule

// file: tb/dchr_rx_core_props.sv
/*
  Checker of bus answers and status readback.
  Assumes a bind into dchr_rx_core and joint mode writes.
*/
`timescale 1ns/1ps
module dchr_rx_core_props #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] rd_addr_q;
  logic [2:0] mode_q;
  wire is_stat = s_axi_rvalid && rd_addr_q[7:2] == dchr_pkg::OFS_STAT[7:2];
  wire is_cnt = s_axi_rvalid && rd_addr_q[7:2] == dchr_pkg::OFS_CNT[7:2];
  wire mode_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[7:2] == 6'h00;
  // Mode follows joint address/data takes only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_addr_q <= 8'h00;
      mode_q <= 3'h0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
        rd_addr_q <= 8'(s_axi_araddr);
      if (mode_wr)
        mode_q <= s_axi_wdata[2:0];
    end
  end
  a_stat_single: assert property (is_stat |-> !(s_axi_rdata[0] && s_axi_rdata[1]))
    else $error("Two events shown");
  a_queue_depth: assert property (is_stat && !(s_axi_rdata[0] || s_axi_rdata[1]) |-> s_axi_rdata[17:16] == 2'h0)
    else $error("Count without head");
  a_tei_hidden: assert property (is_stat && mode_q[2:1] == 2'h3 |-> !s_axi_rdata[12])
    else $error("TEI match in mode 11x");
  a_count_fields: assert property (is_cnt |-> s_axi_rdata[15:5] == 11'h000 && s_axi_rdata[31:28] == 4'h0)
    else $error("Stray count bits");
  a_unmapped_read: assert property (s_axi_rvalid && rd_addr_q >= 8'h24 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
endmodule

// file: tb/dchr_host_model.sv
/*
  Host model: bus master that services receive events.
  Waits for every answer; the bench timeout cuts a hang.
*/
`timescale 1ns/1ps
module dchr_host_model (
  // Clock
  input wire logic aclk,
  // Write side
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read side
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic [7:0] got[$];
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  // Drains the head event, then acknowledges it
  task automatic service(output logic [31:0] st, output logic [31:0] cn);
    logic [31:0] d;
    logic [1:0] r;
    cn = 32'h0;
    rd(dchr_pkg::OFS_STAT, st, r);
    if (st[1:0] == 2'h0)
      return;
    rd(dchr_pkg::OFS_CNT, cn, r);
    repeat ((cn[4:0] == 5'h00) ? 32 : int'(cn[4:0]))
    begin
      rd(dchr_pkg::OFS_DATA, d, r);
      got.push_back(d[7:0]);
    end
    wr(dchr_pkg::OFS_CMD, 32'h1, r);
  endtask
endmodule

// file: tb/test_dchr_rx_core.sv
/*
  Bench: deframed frames in, checks through the host model.
  Assumes a one-clock deframed byte stream.
*/
`timescale 1ns/1ps
module test_dchr_rx_core;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tei_a, tei_b, sap_a, sap_b;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, st, cn, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] b[$], ex[$];
  logic [7:0] ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
  dchr_pkg::dchr_rx_t rx_in;
  int error_cnt = 0, total_checks = 0, cycles = 0, seed = 9861;
  dchr_rx_core i_dchr_rx_core (.*);
  dchr_host_model i_dchr_host_model (.*);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Last ncrc bytes are the check field
  task automatic send(input logic [7:0] fb[$], input int ncrc);
    dchr_pkg::dchr_rx_t x;
    x = '0;
    x.sof = 1'b1;
    @(posedge aclk) rx_in <= x;
    x.sof = 1'b0;
    x.valid = 1'b1;
    foreach (fb[i])
    begin
      x.data = fb[i];
      x.is_crc = (i >= fb.size() - ncrc);
      @(posedge aclk) rx_in <= x;
    end
    x = '0;
    x.eof = 1'b1;
    x.crc_ok = 1'b1;
    @(posedge aclk) rx_in <= x;
    @(posedge aclk) rx_in <= '0;
    repeat (2) @(posedge aclk);
  endtask
  function automatic logic hit(input logic [2:0] m, input logic [7:0] b0, input logic [7:0] b1);
    logic sh, th;
    sh = b0 == sap_a || b0 == sap_b || b0 == dchr_pkg::GRP_SAPI_A || b0 == dchr_pkg::GRP_SAPI_B;
    th = b1 == tei_a || b1 == tei_b || b1 == dchr_pkg::GRP_TEI;
    case (m)
      3'h5: return th;
      3'h6: return 1'b1;
      3'h7: return sh;
      3'h1, 3'h3: return sh && th;
      default: return b0 == tei_a || b0 == tei_b;
    endcase
  endfunction
  task automatic frame(input logic [2:0] m, input logic [7:0] b0, input logic [7:0] b1, input int n);
    int sk;
    b = {b0, b1};
    repeat (n + 2) b.push_back(8'($random(seed)));
    i_dchr_host_model.wr(dchr_pkg::OFS_MODE, {29'h0, m}, rs);
    send(b, 2);
    sk = (m == 3'h6) ? 0 : (m == 3'h7) ? 1 : (m == 3'h2) ? 2 : 3;
    // Check field is stored only in mode 110
    ex = b[sk:b.size() - ((m == 3'h6) ? 1 : 3)];
    if (hit(m, b0, b1) && m[2:1] != 2'h3)
    begin
      i_dchr_host_model.rd(dchr_pkg::OFS_CTRL, d, rs);
      chk(d, {24'h0, b[sk - 1]});
      i_dchr_host_model.rd(dchr_pkg::OFS_SAPI_CAPTURE_REG, d, rs);
      if (m == 3'h5)
        chk(d, {24'h0, b0});
    end
    i_dchr_host_model.got.delete();
    i_dchr_host_model.service(st, cn);
    if (!hit(m, b0, b1))
    begin
      chk(st, 32'h0);
      return;
    end
    if (ex.size() > 32)
    begin
      chk(st[1:0], 2'h1);
      i_dchr_host_model.service(st, cn);
    end
    chk({st[12:8], st[1:0]}, {m[2:1] != 2'h3, 6'h16});
    chk(cn, {4'h0, 12'(ex.size()), 11'h0, 5'(ex.size())});
    chk(i_dchr_host_model.got.size(), ex.size());
    foreach (ex[i]) chk(i_dchr_host_model.got[i], ex[i]);
  endtask
  initial
  begin
    aresetn = 1'b0;
    rx_in = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    r = $random(seed);
    tei_a = {2'h0, r[5:0]};
    tei_b = {2'h1, r[5:0]};
    sap_a = {2'h0, r[11:8], 2'h0};
    sap_b = {2'h1, r[11:8], 2'h0};
    foreach (ofs[i])
    begin
      i_dchr_host_model.rd(ofs[i], d, rs);
      chk(d, 32'h0);
      chk(rs, (i == 5) ? dchr_pkg::RESP_SLVERR : dchr_pkg::RESP_OKAY);
    end
    i_dchr_host_model.wr(8'h40, 32'h1, rs);
    chk(rs, dchr_pkg::RESP_SLVERR);
    i_dchr_host_model.wr(dchr_pkg::OFS_TEI, {16'h0, tei_b, tei_a}, rs);
    i_dchr_host_model.wr(dchr_pkg::OFS_SAPI, {16'h0, sap_b, sap_a}, rs);
    i_dchr_host_model.rd(dchr_pkg::OFS_TEI, d, rs);
    chk(d, {16'h0, tei_b, tei_a});
    frame(3'h6, 8'($random(seed)), 8'($random(seed)), 6);
    frame(3'h6, 8'($random(seed)), 8'($random(seed)), 36);
    frame(3'h7, sap_a, 8'h00, 5);
    frame(3'h7, dchr_pkg::GRP_SAPI_A, 8'h11, 5);
    frame(3'h7, dchr_pkg::GRP_SAPI_B, 8'h22, 5);
    frame(3'h7, 8'h80, 8'h33, 5);
    frame(3'h5, 8'($random(seed)), tei_b, 7);
    frame(3'h5, 8'($random(seed)), dchr_pkg::GRP_TEI, 4);
    frame(3'h5, 8'($random(seed)), 8'h80, 4);
    frame(3'h2, tei_a, 8'($random(seed)), 4);
    frame(3'h2, dchr_pkg::GRP_TEI, 8'h44, 4);
    frame(3'h3, sap_b, dchr_pkg::GRP_TEI, 5);
    frame(3'h1, sap_a, tei_b, 4);
    // Third short frame finds the queue full
    i_dchr_host_model.wr(dchr_pkg::OFS_MODE, 32'h6, rs);
    ex.delete();
    for (int k = 0; k < 3; k++)
    begin
      b.delete();
      repeat (6) b.push_back(8'($random(seed)));
      send(b, 2);
      if (k < 2)
        ex = {ex, b};
    end
    i_dchr_host_model.rd(dchr_pkg::OFS_STAT, d, rs);
    chk({d[17:16], d[2]}, 3'h5);
    i_dchr_host_model.got.delete();
    i_dchr_host_model.service(st, cn);
    i_dchr_host_model.service(st, cn);
    foreach (ex[i]) chk(i_dchr_host_model.got[i], ex[i]);
    i_dchr_host_model.wr(dchr_pkg::OFS_CMD, 32'h2, rs);
    i_dchr_host_model.rd(dchr_pkg::OFS_STAT, d, rs);
    chk(d, 32'h0);
    stop_test();
  end
endmodule
bind dchr_rx_core dchr_rx_core_props #(.ADDR_W(ADDR_W)) i_dchr_rx_core_props (.*);
